/* src/pafu_pkg.sv */
// pafu_pkg: constants and types shared by the arithmetic flags unit
// assumes: single clock domain, plain register port, no interrupt logic
package pafu_pkg;
	// ----------------------------------------------------------------
	// register map (word index on the plain port)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_OPA = 4'h0;
	localparam logic [3:0] ADDR_OPB = 4'h1;
	localparam logic [3:0] ADDR_CMD = 4'h2;
	localparam logic [3:0] ADDR_RES = 4'h3;
	localparam logic [3:0] ADDR_FLAGS = 4'h4;
	localparam logic [3:0] ADDR_CAUSE_A = 4'h5;
	localparam logic [3:0] ADDR_CAUSE_B = 4'h6;
	localparam logic [3:0] ADDR_ERRIN = 4'h7;
	localparam logic [3:0] ADDR_FCLEAR = 4'h8;
	// ----------------------------------------------------------------
	// operation codes, cmd bits [3:0]; bit 4 selects double length
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_ADD = 4'h0;
	localparam logic [3:0] OP_SUB = 4'h1;
	localparam logic [3:0] OP_ADDC = 4'h2;
	localparam logic [3:0] OP_SUBC = 4'h3;
	localparam logic [3:0] OP_DIVS = 4'h4;
	localparam logic [3:0] OP_DIVU = 4'h5;
	localparam logic [3:0] OP_BCDCHK = 4'h6;
	localparam logic [3:0] OP_FNORM = 4'h7;
	localparam int CMD_DBL_BIT = 4;
	// flag register bits
	localparam int FLG_CARRY = 0;
	localparam int FLG_ERR = 1;
	localparam int FLG_OVF = 2;
	localparam int FLG_UNF = 3;
	localparam int FLG_FNEG = 4;
	// fclear register: bit 0 carry, bit 1 error (bit_reset_function_code)
	localparam int CLR_CARRY = 0;
	localparam int CLR_ERR = 1;
	// ----------------------------------------------------------------
	// cause identification bits (10 causes)
	// ----------------------------------------------------------------
	localparam int NCAUSE = 10;
	localparam int C_IO_NOANS = 0;
	localparam int C_IO_PAR = 1;
	localparam int C_BOUND = 2;
	localparam int C_ABOUND = 3;
	localparam int C_DIV = 4;
	localparam int C_BCD = 5;
	localparam int C_TABLE = 6;
	localparam int C_ENC = 7;
	localparam int C_DEST = 8;
	localparam int C_NEST = 9;
	// word a holds io causes, word b holds the rest
	localparam logic [15:0] CAUSE_A_MASK = 16'h0003;
	localparam logic [15:0] CAUSE_B_MASK = 16'h03FC;
	// ----------------------------------------------------------------
	// float layout and integer limits
	// ----------------------------------------------------------------
	localparam int F_SIGN = 31;
	localparam logic [7:0] F_EXP_ZERO = 8'h00;
	localparam logic [7:0] F_EXP_ONES = 8'hFF;
	localparam logic [7:0] F_EXP_MAX = 8'hFE;
	localparam logic [22:0] F_MAN_MAX = 23'h7FFFFF;
	localparam logic [15:0] SMAX16 = 16'h7FFF;
	localparam logic [31:0] SMAX32 = 32'h7FFFFFFF;
	localparam logic [31:0] UMAX16 = 32'h0000FFFF;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam int NDIG = 8;
	localparam logic [31:0] ZERO32 = 32'h00000000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam int DIV_STEPS = 32;
	localparam logic [5:0] DIV_LAST = 6'h1F;
	localparam logic [5:0] CNT_ZERO = 6'h00;
	localparam logic [5:0] CNT_ONE = 6'h01;
	typedef enum logic [1:0] {
		PAFU_IDLE = 2'b00,
		PAFU_DIV = 2'b01,
		PAFU_DONE = 2'b11
	} pafu_state_type;
endpackage : pafu_pkg

/* src/pafu_div_if.sv */
// pafu_div_if: request and answer of the serial divider
// assumes: both ends on clk_in of the flags unit
interface pafu_div_if;
	logic start;
	logic sgn;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic done;
	logic [31:0] quotient;
	modport ctrl (output start, output sgn, output dividend, output divisor,
		input done, input quotient);
	modport unit (input start, input sgn, input dividend, input divisor,
		output done, output quotient);
endinterface : pafu_div_if

/* src/pafu_divider.sv */
// pafu_divider: 32-step restoring divider, signed or unsigned
// assumes: divisor non-zero (zero is caught by the controller)
module pafu_divider (
	input wire logic clk_in,
	input wire logic rst_b_in,
	pafu_div_if.unit div
);
	typedef struct packed {
		pafu_pkg::pafu_state_type st;
		logic [5:0] cnt;
		logic [31:0] rem;
		logic [31:0] quo;
		logic [31:0] dsr;
		logic neg;
	} pafu_div_state_type;
	pafu_div_state_type s_r;
	pafu_div_state_type s_nxt;
	// one spare bit: with a divisor of 2^31 or more the shifted remainder needs 33 bits
	logic [33:0] trial;

	// ----------------------------------------------------------------
	// one quotient bit per clock; slow but small
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		trial = {1'b0, s_r.rem, s_r.quo[31]} - {2'b00, s_r.dsr};
		unique case (s_r.st)
			pafu_pkg::PAFU_IDLE: begin
				if (div.start) begin
					s_nxt.st = pafu_pkg::PAFU_DIV;
					s_nxt.cnt = pafu_pkg::CNT_ZERO;
					s_nxt.rem = pafu_pkg::ZERO32;
					s_nxt.quo = (div.sgn && div.dividend[31]) ? -div.dividend : div.dividend;
					s_nxt.dsr = (div.sgn && div.divisor[31]) ? -div.divisor : div.divisor;
					s_nxt.neg = div.sgn && (div.dividend[31] ^ div.divisor[31]);
				end
			end
			pafu_pkg::PAFU_DIV: begin
				if (!trial[33]) begin
					s_nxt.rem = trial[31:0];
				end else begin
					s_nxt.rem = {s_r.rem[30:0], s_r.quo[31]};
				end
				s_nxt.quo = {s_r.quo[30:0], ~trial[33]};
				s_nxt.cnt = s_r.cnt + pafu_pkg::CNT_ONE;
				if (s_r.cnt == pafu_pkg::DIV_LAST) begin
					s_nxt.st = pafu_pkg::PAFU_DONE;
				end
			end
			pafu_pkg::PAFU_DONE: begin
				s_nxt.quo = s_r.neg ? -s_r.quo : s_r.quo;
				s_nxt.st = pafu_pkg::PAFU_IDLE;
			end
			default: begin
				s_nxt.st = pafu_pkg::PAFU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign div.done = (s_r.st == pafu_pkg::PAFU_DONE);
	assign div.quotient = s_r.neg ? -s_r.quo : s_r.quo;
endmodule // pafu_divider

/* src/pafu_top.sv */
// pafu_top: arithmetic status unit of the ladder instruction engine
// assumes: one clock, plain register port, causes from other units written to ADDR_ERRIN
//
// Functional notes
// RL1: negative integers are two's complement at 16 and 32 bits.
// RL2: signed limits are 32767 single and 2147483647 double length.
// RL3: result above the positive limit flags overflow, wraps negative.
// RL4: result below -32768 or -2147483648 flags underflow, wraps positive.
// RL5: fixed point arithmetic is only 16 or 32 bits wide.
// RL6: add or subtract with carry sets carry on carry out or borrow.
// RL7: carry is raised when the unsigned result wraps past zero.
// RL8: software clears carry first, then chains carry operations for long data.
// RL9: any detected calculation error turns the error flag on.
// RL10: error flag is sticky until the explicit bit reset clears it.
// RL11: ten error causes are recognised, each with its own flag.
// RL12: cause flags are set in both cause words with the error flag; the code sets each cause only in its own word, a for io causes, b for the rest.
// RL13: float has sign, fraction below one, exponent -127 to 128.
// RL14: float sign bit 0 is positive, 1 is negative.
// RL15: sign bit 31, 8-bit exponent, 23-bit mantissa; zero and saturate cases.
// RL16: zero divisor or unsigned quotient overflow sets division cause.
// RL17: a decimal nibble above 9 sets the decimal digit cause.
module pafu_top (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic busy_out,
	output logic carry_flag_bit_out,
	output logic calc_error_flag_bit_out
);
	typedef struct packed {
		logic [31:0] opa;
		logic [31:0] opb;
		logic [31:0] res;
		logic carry;
		logic err;
		logic ovf;
		logic unf;
		logic fneg;
		logic [15:0] cause_a;
		logic [15:0] cause_b;
		logic busy;
		logic divu;
		logic dbl;
		logic [31:0] rdata;
	} pafu_top_state_type;
	pafu_top_state_type s_r;
	pafu_top_state_type s_nxt;

	pafu_div_if div_bus ();

	// bcd digit check, used for both operands
	function automatic logic bcd_bad(input logic [31:0] v, input logic dbl);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < pafu_pkg::NDIG; i++) begin
			if ((dbl || i < pafu_pkg::NDIG / 2) && v[i*4 +: 4] > pafu_pkg::BCD_MAX) begin
				bad = 1'b1; // see RL17
			end
		end
		return bad;
	endfunction

	// place one cause into the word it belongs to
	function automatic logic [15:0] cause_bit(input int idx);
		logic [15:0] w;
		w = pafu_pkg::ZERO16;
		w[idx] = 1'b1;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// arithmetic datapath
	// ----------------------------------------------------------------
	// the adder is always computed from the stored operands; the
	// command write only decides which of its results are kept.
	// this costs a 33-bit and a 17-bit adder that toggle on every operand
	// write, traded for a flag update in the same edge as the command.
	// single length uses the low halves only; the upper half of the
	// result is forced to zero so software never sees stale bits.
	// overflow and underflow are judged from operand and result signs,
	// which needs no wider adder than the word itself.
	// carry out and borrow share one path: subtraction is a + ~b + 1,
	// so a borrow is the missing carry out, and the flag is inverted.
	// with a borrow coming in, the +1 is simply left out.
	// hazard: op and dbl_cmd are decoded from the write data even when
	// no command is written, so every use below is qualified by the
	// command strobe.
	logic [3:0] op;
	logic dbl_cmd;
	logic cin;
	logic sub;
	logic [32:0] sum32;
	logic [16:0] sum16;
	logic [31:0] bsel;
	logic [31:0] ares;
	logic acarry;
	logic aovf;
	logic aunf;
	logic [7:0] fexp;
	logic [31:0] fres;
	logic [15:0] new_a;
	logic [15:0] new_b;
	logic raise;

	always_comb begin
		op = wdata_in[3:0];
		dbl_cmd = wdata_in[pafu_pkg::CMD_DBL_BIT];
		sub = (op == pafu_pkg::OP_SUB) || (op == pafu_pkg::OP_SUBC);
		cin = ((op == pafu_pkg::OP_ADDC) || (op == pafu_pkg::OP_SUBC)) && s_r.carry;
		bsel = sub ? ~s_r.opb : s_r.opb;
		// subtraction as a + ~b + 1; borrow is the inverse of carry out
		sum32 = {1'b0, s_r.opa} + {1'b0, bsel} + {32'h0, (sub ^ cin)} ; // see RL1
		sum16 = {1'b0, s_r.opa[15:0]} + {1'b0, bsel[15:0]} + {16'h0, (sub ^ cin)};
		if (sub && cin) begin
			// borrow in: a - b - 1 = a + ~b
			sum32 = {1'b0, s_r.opa} + {1'b0, bsel};
			sum16 = {1'b0, s_r.opa[15:0]} + {1'b0, bsel[15:0]};
		end
		if (dbl_cmd) begin // see RL5
			ares = sum32[31:0];
			acarry = sum32[32] ^ sub; // see RL6, RL7
			// same operand signs, result sign differs: out of range
			aovf = ~s_r.opa[31] & ~bsel[31] & ares[31]; // see RL2, RL3
			aunf = s_r.opa[31] & bsel[31] & ~ares[31]; // see RL4
		end else begin
			ares = {pafu_pkg::ZERO16, sum16[15:0]};
			acarry = sum16[16] ^ sub; // see RL6, RL7
			aovf = ~s_r.opa[15] & ~bsel[15] & ares[15]; // see RL2, RL3
			aunf = s_r.opa[15] & bsel[15] & ~ares[15]; // see RL4
		end
		// float normalise: zero exponent gives zero, all ones saturates
		fexp = s_r.opa[30:23];
		if (fexp == pafu_pkg::F_EXP_ZERO) begin
			fres = {s_r.opa[pafu_pkg::F_SIGN], 31'h0}; // see RL15
		end else if (fexp == pafu_pkg::F_EXP_ONES) begin
			fres = {s_r.opa[pafu_pkg::F_SIGN], pafu_pkg::F_EXP_MAX, pafu_pkg::F_MAN_MAX}; // see RL15
		end else begin
			fres = s_r.opa; // see RL13
		end
	end

	// ----------------------------------------------------------------
	// divider hookup
	// ----------------------------------------------------------------
	// a zero divisor never starts the divider: the cause is raised at
	// once and the result register keeps its old value.
	// the divider latches its operands on start, so software may load
	// new operands while a division is still running.
	// limitation: a signed -2^31 / -1 wraps silently, no cause is set.
	logic div_go;
	logic div_zero;
	logic div_uovf;
	assign div_zero = dbl_cmd ? (s_r.opb == pafu_pkg::ZERO32)
		: (s_r.opb[15:0] == pafu_pkg::ZERO16);
	assign div_go = wr_in && (addr_in == pafu_pkg::ADDR_CMD) && !s_r.busy
		&& ((op == pafu_pkg::OP_DIVS) || (op == pafu_pkg::OP_DIVU)) && !div_zero;
	assign div_bus.start = div_go;
	assign div_bus.sgn = (op == pafu_pkg::OP_DIVS);
	// single length operands are widened, sign or zero as the op asks
	assign div_bus.dividend = dbl_cmd ? s_r.opa : (div_bus.sgn
		? {{16{s_r.opa[15]}}, s_r.opa[15:0]} : {pafu_pkg::ZERO16, s_r.opa[15:0]});
	assign div_bus.divisor = dbl_cmd ? s_r.opb : (div_bus.sgn
		? {{16{s_r.opb[15]}}, s_r.opb[15:0]} : {pafu_pkg::ZERO16, s_r.opb[15:0]});
	// unsigned quotient must fit a single length word
	assign div_uovf = s_r.divu && (div_bus.quotient > pafu_pkg::UMAX16); // see RL16

	pafu_divider u_div (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.div(div_bus)
	);

	// ----------------------------------------------------------------
	// command, flag and register logic
	// ----------------------------------------------------------------
	// every cause source only fills new_a or new_b; the error flag and
	// both cause words are then raised from those in one place, so the
	// flag can never come on without a cause or a cause without the flag.
	// a clear and a new cause in the same cycle leave the flag set:
	// losing an error is worse than reporting one twice.
	// a command written while the divider runs is dropped silently;
	// software polls busy before issuing the next one.
	always_comb begin
		s_nxt = s_r;
		new_a = pafu_pkg::ZERO16;
		new_b = pafu_pkg::ZERO16;
		s_nxt.rdata = pafu_pkg::ZERO32;
		// software clears first so any hardware set below wins
		if (wr_in && addr_in == pafu_pkg::ADDR_FCLEAR) begin
			if (wdata_in[pafu_pkg::CLR_CARRY]) begin
				s_nxt.carry = 1'b0; // see RL8
			end
			if (wdata_in[pafu_pkg::CLR_ERR]) begin
				s_nxt.err = 1'b0; // see RL10
				s_nxt.cause_a = pafu_pkg::ZERO16;
				s_nxt.cause_b = pafu_pkg::ZERO16;
			end
		end
		if (wr_in && addr_in == pafu_pkg::ADDR_OPA) begin
			s_nxt.opa = wdata_in;
		end
		if (wr_in && addr_in == pafu_pkg::ADDR_OPB) begin
			s_nxt.opb = wdata_in;
		end
		// external causes from i/o, table, nesting units
		if (wr_in && addr_in == pafu_pkg::ADDR_ERRIN) begin
			new_a = wdata_in[15:0] & pafu_pkg::CAUSE_A_MASK; // see RL11
			new_b = wdata_in[15:0] & pafu_pkg::CAUSE_B_MASK; // see RL11
		end
		if (wr_in && addr_in == pafu_pkg::ADDR_CMD && !s_r.busy) begin
			s_nxt.dbl = dbl_cmd;
			unique case (op)
				pafu_pkg::OP_ADD, pafu_pkg::OP_SUB, pafu_pkg::OP_ADDC, pafu_pkg::OP_SUBC: begin
					s_nxt.res = ares;
					s_nxt.ovf = aovf;
					s_nxt.unf = aunf;
					if (op == pafu_pkg::OP_ADDC || op == pafu_pkg::OP_SUBC) begin
						s_nxt.carry = acarry; // see RL6
					end
				end
				pafu_pkg::OP_DIVS, pafu_pkg::OP_DIVU: begin
					if (div_zero) begin
						new_b = cause_bit(pafu_pkg::C_DIV); // see RL16
					end else begin
						s_nxt.busy = 1'b1;
						s_nxt.divu = (op == pafu_pkg::OP_DIVU);
					end
				end
				pafu_pkg::OP_BCDCHK: begin
					if (bcd_bad(s_r.opa, dbl_cmd) || bcd_bad(s_r.opb, dbl_cmd)) begin
						new_b = cause_bit(pafu_pkg::C_BCD); // see RL17
					end
				end
				pafu_pkg::OP_FNORM: begin
					s_nxt.res = fres;
					s_nxt.fneg = s_r.opa[pafu_pkg::F_SIGN]; // see RL14
				end
				default: begin
					s_nxt.res = s_r.res;
				end
			endcase
		end
		if (s_r.busy && div_bus.done) begin
			s_nxt.busy = 1'b0;
			s_nxt.res = s_r.dbl ? div_bus.quotient : {pafu_pkg::ZERO16, div_bus.quotient[15:0]};
			if (div_uovf) begin
				new_b = new_b | cause_bit(pafu_pkg::C_DIV); // see RL16
			end
		end
		// error and causes set together in one edge
		raise = (new_a != pafu_pkg::ZERO16) || (new_b != pafu_pkg::ZERO16);
		if (raise) begin
			s_nxt.err = 1'b1; // see RL9
			s_nxt.cause_a = s_nxt.cause_a | new_a; // see RL12
			s_nxt.cause_b = s_nxt.cause_b | new_b; // see RL12
		end
		if (rd_in) begin
			unique case (addr_in)
				pafu_pkg::ADDR_OPA: s_nxt.rdata = s_r.opa;
				pafu_pkg::ADDR_OPB: s_nxt.rdata = s_r.opb;
				pafu_pkg::ADDR_RES: s_nxt.rdata = s_r.res;
				pafu_pkg::ADDR_FLAGS: s_nxt.rdata = {27'h0, s_r.fneg, s_r.unf, s_r.ovf,
					s_r.err, s_r.carry};
				pafu_pkg::ADDR_CAUSE_A: s_nxt.rdata = {pafu_pkg::ZERO16, s_r.cause_a};
				pafu_pkg::ADDR_CAUSE_B: s_nxt.rdata = {pafu_pkg::ZERO16, s_r.cause_b};
				default: s_nxt.rdata = pafu_pkg::ZERO32;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_out = s_r.rdata;
	assign busy_out = s_r.busy;
	assign carry_flag_bit_out = s_r.carry;
	assign calc_error_flag_bit_out = s_r.err;
endmodule // pafu_top

/* sim/pafu_checker.sv */
// pafu_checker: port-level assertions for the arithmetic flags unit
// assumes: bound to pafu_top, one clock, active-low asynchronous reset
module pafu_checker (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic busy_out,
	input wire logic carry_flag_bit_out,
	input wire logic calc_error_flag_bit_out
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	logic [5:0] busy_cnt_r;
	logic [5:0] busy_cnt_nxt;
	// counts busy cycles so the divider length is checked without a long repetition
	always_comb begin
		busy_cnt_nxt = busy_out ? busy_cnt_r + 6'h01 : 6'h00;
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_cnt_r <= 6'h00;
		end else begin
			busy_cnt_r <= busy_cnt_nxt;
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// 32 shift steps plus the done cycle keep busy high for 33 cycles
	a_div_busy_len: assert property ($fell(busy_out) |-> busy_cnt_r == 6'h21)
		else $error("divider busy length wrong");
	a_busy_start_cause: assert property ($rose(busy_out) |->
		$past(wr_in && addr_in == 4'h2 && wdata_in[3:1] == 3'h2))
		else $error("busy rose without a division command");
	a_err_sticky: assert property (calc_error_flag_bit_out &&
		!(wr_in && addr_in == 4'h8 && wdata_in[1]) |=> calc_error_flag_bit_out)
		else $error("error flag dropped without a clear");
	a_err_clear: assert property (wr_in && addr_in == 4'h8 && wdata_in[1] && !busy_out
		|=> !calc_error_flag_bit_out)
		else $error("error flag not cleared");
	a_err_inject_set: assert property (wr_in && addr_in == 4'h7 &&
		wdata_in[9:0] != 10'h000 |=> calc_error_flag_bit_out)
		else $error("injected cause did not raise error flag");
	a_carry_cause: assert property ($changed(carry_flag_bit_out) |->
		$past(wr_in && (addr_in == 4'h8 || addr_in == 4'h2 && wdata_in[3:1] == 3'h1)))
		else $error("carry changed without a carry operation");
	a_carry_clear: assert property (wr_in && addr_in == 4'h8 && wdata_in[0]
		|=> !carry_flag_bit_out)
		else $error("carry not cleared");
	a_flag_read: assert property (rd_in && addr_in == 4'h4 && !busy_out |=>
		rdata_out[1:0] == $past({calc_error_flag_bit_out, carry_flag_bit_out}))
		else $error("flag word disagrees with flag pins");
endmodule // pafu_checker

bind pafu_top pafu_checker chk_u (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.rdata_out, .busy_out, .carry_flag_bit_out, .calc_error_flag_bit_out);

/* sim/pafu_top_test.sv */
// pafu_top_test: directed register-level tests of the arithmetic flags unit
// assumes: pafu_top alone, the bench plays the plain register port master
module pafu_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h00000000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic busy_out;
	logic carry_flag_bit_out;
	logic calc_error_flag_bit_out;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [31:0] f_in [5] = '{32'h3F800000, 32'hFFFFFFFF, 32'h807FFFFF, 32'h7F800000, 32'h00123456};
	logic [31:0] f_out [5] = '{32'h3F800000, 32'hFF7FFFFF, 32'h80000000, 32'h7F7FFFFF, 32'h0};
	logic [31:0] f_sg [5] = '{32'h0, 32'h10, 32'h10, 32'h0, 32'h0};
	// ----------------------------------------------------------------
	// clock, design, watchdog
	// ----------------------------------------------------------------
	always #10 clk_in = ~clk_in;
	pafu_top dut_u (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .busy_out, .carry_flag_bit_out, .calc_error_flag_bit_out);
	// the whole run needs a few hundred cycles, so this only trips on a hang
	always @(posedge clk_in) begin
		cycles++;
		if (cycles > 20000) begin
			fail("watchdog expired");
			print_verdict;
		end
	end
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task print_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task fail(input string m);
		n_errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	// a spare edge before each strobe keeps one assignment per signal per step
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample mid-cycle
	task chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		compares++;
		if ((rdata_out & m) !== e)
			fail($sformatf("addr %h read %h expected %h", a, rdata_out, e));
	endtask
	task pin(input logic v, input logic e);
		compares++;
		if (v !== e)
			fail("flag pin mismatch");
	endtask
	task op(input logic [31:0] a, input logic [31:0] b, input logic [4:0] c);
		wr(4'h0, a);
		wr(4'h1, b);
		wr(4'h2, {27'h0, c});
	endtask
	// busy is looked at mid-cycle, away from the edge that launches it
	task wait_idle;
		int k;
		k = 0;
		@(negedge clk_in);
		while (busy_out !== 1'b0 && k < 50) begin
			@(negedge clk_in);
			k++;
		end
		if (k >= 50)
			fail("divider never finished");
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		chk(4'h4, 32'h0);
		chk(4'h6, 32'h0);
		op(32'h00007530, 32'h00002710, 5'h00);
		chk(4'h3, 32'h00009C40);
		chk(4'h4, 32'h4, 32'hD);
		op(32'h0000B1E0, 32'h00007530, 5'h01);
		chk(4'h3, 32'h00003CB0);
		chk(4'h4, 32'h8, 32'hD);
		op(32'hABCD7FFE, 32'h1, 5'h00);
		chk(4'h3, 32'h00007FFF);
		chk(4'h4, 32'h0, 32'hD);
		op(32'h7FFFFFFF, 32'h1, 5'h10);
		chk(4'h3, 32'h80000000);
		chk(4'h4, 32'h4, 32'hC);
		op(32'h80000000, 32'h1, 5'h11);
		chk(4'h3, 32'h7FFFFFFF);
		chk(4'h4, 32'h8, 32'hC);
		op(32'hFFFFFFFF, 32'hFFFFFFFF, 5'h10);
		chk(4'h3, 32'hFFFFFFFE);
		chk(4'h4, 32'h0, 32'hC);
		// carry set, cleared, then a two-word chained sum
		op(32'h0000FFFF, 32'h1, 5'h02);
		chk(4'h3, 32'h0);
		pin(carry_flag_bit_out, 1'b1);
		wr(4'h8, 32'h1);
		chk(4'h4, 32'h0, 32'h1);
		op(32'hFFFFFFFF, 32'h1, 5'h12);
		chk(4'h4, 32'h1, 32'h1);
		op(32'h1, 32'h1, 5'h00);
		chk(4'h4, 32'h1, 32'h1);
		op(32'h0, 32'h0, 5'h12);
		chk(4'h3, 32'h1);
		op(32'h0, 32'h1, 5'h03);
		chk(4'h3, 32'h0000FFFF);
		chk(4'h4, 32'h1, 32'h1);
		op(32'h5, 32'h2, 5'h03);
		chk(4'h3, 32'h2);
		// signed division with a refused command while busy
		op(32'hFFFFFF9C, 32'h7, 5'h14);
		wr(4'h2, 32'h0);
		wait_idle;
		chk(4'h3, 32'hFFFFFFF2);
		op(32'h5, 32'h0, 5'h05);
		chk(4'h3, 32'hFFFFFFF2);
		chk(4'h6, 32'h10);
		pin(calc_error_flag_bit_out, 1'b1);
		op(32'h1, 32'h1, 5'h00);
		chk(4'h4, 32'h2, 32'h2);
		wr(4'h8, 32'h2);
		chk(4'h4, 32'h0, 32'h2);
		chk(4'h6, 32'h0);
		op(32'h00010000, 32'h1, 5'h15);
		wait_idle;
		chk(4'h6, 32'h10);
		wr(4'h8, 32'h2);
		// decimal digit checks, low and top nibble
		op(32'h99999999, 32'h12345678, 5'h16);
		chk(4'h4, 32'h0, 32'h2);
		op(32'h0000001A, 32'h0, 5'h16);
		chk(4'h6, 32'h20);
		wr(4'h8, 32'h2);
		op(32'h0, 32'hA0000000, 5'h16);
		chk(4'h6, 32'h20);
		wr(4'h8, 32'h2);
		// float word normalise: plain, saturate, zero exponent
		for (int i = 0; i < 5; i++) begin
			op(f_in[i], 32'h0, 5'h17);
			chk(4'h3, f_out[i]);
			chk(4'h4, f_sg[i], 32'h10);
		end
		// every cause lands in its own bit of the right word
		for (int i = 0; i < 10; i++) begin
			wr(4'h7, 32'h1 << i);
			chk(4'h5, (32'h1 << i) & 32'h3);
			chk(4'h6, (32'h1 << i) & 32'h3FC);
			chk(4'h4, 32'h2, 32'h2);
			wr(4'h8, 32'h2);
		end
		chk(4'hF, 32'h0);
		chk(4'h2, 32'h0);
		print_verdict;
	end
endmodule // pafu_top_test
